// ---- verilog/dfm_defines.vh ----
`ifndef DFM_DEFINES_VH
`define DFM_DEFINES_VH
// ----------------------------------------------------------------
// zero-based coil addresses, one-based register numbers and field layouts
// ----------------------------------------------------------------
`define DFM_WORD_W 16
`define DFM_BCAST_ADDR 8'h00
`define DFM_UNIT_MAX 8'hF7
// coil areas, base of each 16-coil word (coil n sits at n-1)
`define DFM_COIL_CMD_BASE 16'h0000
`define DFM_COIL_REF_BASE 16'h0010
`define DFM_COIL_STATE_BASE 16'h0020
`define DFM_COIL_FBK_BASE 16'h0030
`define DFM_COIL_NVSEL 16'h0040
// holding register numbers without the holding_register_prefix prefix
`define DFM_HR_ERR_NUM 16'h0007
`define DFM_HR_INDEX_NUM 16'h0009
`define DFM_HR_PARAM_LO_NUM 16'h0064
`define DFM_HR_PARAM_HI_NUM 16'hC34F
`define DFM_HR_CMD_NUM 16'hC350
`define DFM_HR_REF_NUM 16'hC35A
`define DFM_HR_STATE_NUM 16'hC418
`define DFM_HR_MAV_NUM 16'hC422
// registers per parameter group slot
`define DFM_PARAM_STRIDE 16'h000A
// reset values
`define DFM_CMD_RST 16'h0000
`define DFM_REF_RST 16'h0000
`define DFM_INDEX_RST 16'h0000
`define DFM_ERR_RST 16'h0000
// command word field positions
`define DFM_CMD_PRESET_LSB 0
`define DFM_CMD_DC_BRAKE 2
`define DFM_CMD_COAST 3
`define DFM_CMD_QSTOP 4
`define DFM_CMD_FREEZE 5
`define DFM_CMD_START 6
`define DFM_CMD_RESET 7
`define DFM_CMD_JOG 8
`define DFM_CMD_RAMP2 9
`define DFM_CMD_VALID 10
`define DFM_CMD_RELAY1 11
`define DFM_CMD_RELAY2 12
`define DFM_CMD_SETUP_LSB 13
`define DFM_CMD_REVERSE 15
`endif

// ---- verilog/dfm_data_map.v ----
`timescale 1ns/10ps
`include "dfm_defines.vh"

// Function
// - a coil is one bit and a holding register is one 16-bit word.
// - coil addresses are zero-based, coil n travels as n minus one.
// - holding register n travels without the 4 prefix as n minus one.
// - coils 1-16 hold the command word and 17-32 the speed reference, written by the master.
// - coils 33-48 show the state word and 49-64 the feedback value, read by the master.
// - coil 65 chooses RAM only (0) or RAM plus EEPROM (1) for parameter writes.
// - command coils 3-13 and 16 drive brake, coast, stop, freeze, start, reset, jog, ramp, valid, relays, reverse.
// - state coils 33, 34, 35 show control ready, drive ready and safety closed.
// - state coils 46, 47, 48 show voltage warning, current limit and thermal warning.
// - state coils 36, 40-44 show alarm, warning, at reference, auto, in range, running; 37-39, 45 read 0.
// - register 7 returns the last parameter-interface error code; 1 to 6 are reserved.
// - register 9 holds the array index used for indexed parameters.
// - registers 100 to 49999 map parameters, ten registers per parameter.
// - registers 50000 and 50010 take the command word and bus reference.
// - registers 50200 and 50210 return the state word and main actual value.
// - unit addresses 1-247 are answered, address 0 is a broadcast with no answer.
module dfm_data_map (
  input wire core_clk,
  input wire reset,
  input wire clk_en,
  input wire [7:0] own_unit_addr,
  input wire req_valid,
  output wire req_ready,
  input wire [7:0] req_unit,
  input wire req_is_coil,
  input wire req_write,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  output reg resp_valid,
  output reg resp_error,
  output reg [15:0] resp_data,
  output reg param_req,
  output reg param_write,
  output reg [12:0] param_number,
  output reg [3:0] param_word,
  output reg [15:0] param_wdata,
  output reg param_store_nv,
  output reg [15:0] param_array_index,
  input wire param_ack,
  input wire [15:0] param_rdata,
  input wire param_err,
  input wire [15:0] param_err_code,
  input wire stat_control_ready,
  input wire stat_drive_ready,
  input wire stat_safety_closed,
  input wire stat_alarm,
  input wire stat_warning,
  input wire stat_at_reference,
  input wire stat_auto_mode,
  input wire stat_in_freq_range,
  input wire stat_running,
  input wire stat_voltage_warning,
  input wire stat_current_limit,
  input wire stat_thermal_warning,
  input wire [15:0] main_actual_value,
  output wire [1:0] preset_ref_sel,
  output wire dc_brake_off,
  output wire coast_off,
  output wire quick_stop_off,
  output wire freeze_off,
  output wire start_run,
  output wire fault_reset,
  output wire jog,
  output wire ramp_two,
  output wire data_valid,
  output wire relay1_on,
  output wire relay2_on,
  output wire [1:0] setup_sel,
  output wire reverse,
  output wire [15:0] speed_reference,
  output wire store_nonvolatile
);

  // ----------------------------------------------------------------
  // states and storage
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_q;
  reg resp_due_q;
  reg [15:0] drive_command_word_q;
  reg [15:0] bus_speed_reference_q;
  reg nv_select_q;
  reg [15:0] parameter_array_index_q;
  reg [15:0] last_error_code_q;

  wire [15:0] drive_state_word;
  wire [15:0] hr_num;
  wire addressed;
  wire broadcast;
  wire take;
  wire [15:0] param_num_full;
  wire [15:0] param_word_full;

  // register number with the one-offset restored
  function [15:0] to_number;
    input [15:0] addr;
    begin
      to_number = addr + 16'h0001;
    end
  endfunction

  // true when the holding register number falls in the parameter area
  function in_param_area;
    input [15:0] num;
    begin
      in_param_area = (num >= `DFM_HR_PARAM_LO_NUM) && (num <= `DFM_HR_PARAM_HI_NUM);
    end
  endfunction

  // one coil out of a 16-bit word, low coil at bit 0
  function coil_bit;
    input [15:0] word;
    input [3:0] pos;
    begin
      coil_bit = word[pos];
    end
  endfunction

  // ----------------------------------------------------------------
  // state word assembly and decoding
  // ----------------------------------------------------------------
  // unused positions tie to zero so the master never sees stale bits
  assign drive_state_word = {stat_thermal_warning, stat_current_limit,
    stat_voltage_warning, 1'b0, stat_running, stat_in_freq_range,
    stat_auto_mode, stat_at_reference, stat_warning, 3'b000, stat_alarm,
    stat_safety_closed, stat_drive_ready, stat_control_ready};

  assign hr_num = to_number(req_addr);
  assign broadcast = (req_unit == `DFM_BCAST_ADDR);
  assign addressed = (req_unit == own_unit_addr) && (req_unit != `DFM_BCAST_ADDR)
    && (req_unit <= `DFM_UNIT_MAX);
  assign req_ready = (state_q == ST_IDLE);
  assign take = clk_en && req_valid && req_ready;

  // quotient and remainder by ten; the quotient tops out at 4999, inside 13 bits
  assign param_num_full = hr_num / `DFM_PARAM_STRIDE;
  assign param_word_full = hr_num % `DFM_PARAM_STRIDE;

  // command word fields straight from the stored coils
  assign preset_ref_sel = drive_command_word_q[`DFM_CMD_PRESET_LSB+1:`DFM_CMD_PRESET_LSB];
  assign dc_brake_off = drive_command_word_q[`DFM_CMD_DC_BRAKE];
  assign coast_off = drive_command_word_q[`DFM_CMD_COAST];
  assign quick_stop_off = drive_command_word_q[`DFM_CMD_QSTOP];
  assign freeze_off = drive_command_word_q[`DFM_CMD_FREEZE];
  assign start_run = drive_command_word_q[`DFM_CMD_START];
  assign fault_reset = drive_command_word_q[`DFM_CMD_RESET];
  assign jog = drive_command_word_q[`DFM_CMD_JOG];
  assign ramp_two = drive_command_word_q[`DFM_CMD_RAMP2];
  assign data_valid = drive_command_word_q[`DFM_CMD_VALID];
  assign relay1_on = drive_command_word_q[`DFM_CMD_RELAY1];
  assign relay2_on = drive_command_word_q[`DFM_CMD_RELAY2];
  assign setup_sel = drive_command_word_q[`DFM_CMD_SETUP_LSB+1:`DFM_CMD_SETUP_LSB];
  assign reverse = drive_command_word_q[`DFM_CMD_REVERSE];
  assign speed_reference = bus_speed_reference_q;
  assign store_nonvolatile = nv_select_q;

  // ----------------------------------------------------------------
  // request handling
  // ----------------------------------------------------------------
  // broadcasts apply writes but never answer; reads to broadcast are dropped
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= ST_IDLE;
      resp_due_q <= 1'b0;
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_data <= 16'h0000;
      param_req <= 1'b0;
      param_write <= 1'b0;
      param_number <= 13'h0000;
      param_word <= 4'h0;
      param_wdata <= 16'h0000;
      param_store_nv <= 1'b0;
      param_array_index <= `DFM_INDEX_RST;
      drive_command_word_q <= `DFM_CMD_RST;
      bus_speed_reference_q <= `DFM_REF_RST;
      nv_select_q <= 1'b0;
      parameter_array_index_q <= `DFM_INDEX_RST;
      last_error_code_q <= `DFM_ERR_RST;
    end
    else if (clk_en)
    begin
      resp_valid <= 1'b0;
      param_req <= 1'b0;
      // error capture from the parameter side is independent of requests
      if (param_err)
        last_error_code_q <= param_err_code;
      case (state_q)
        ST_IDLE:
        begin
          if (take && (addressed || (broadcast && req_write)))
          begin
            resp_due_q <= addressed;
            resp_valid <= addressed;
            resp_error <= 1'b0;
            resp_data <= 16'h0000;
            if (req_is_coil)
            begin
              // coil n arrives as n-1, so areas begin on multiples of 16
              if (req_addr < `DFM_COIL_STATE_BASE)
              begin
                if (req_write)
                begin
                  if (req_addr < `DFM_COIL_REF_BASE)
                    drive_command_word_q[req_addr[3:0]] <= req_wdata[0];
                  else
                    bus_speed_reference_q[req_addr[3:0]] <= req_wdata[0];
                end
                else if (req_addr < `DFM_COIL_REF_BASE)
                  resp_data <= {15'h0000, coil_bit(drive_command_word_q, req_addr[3:0])};
                else
                  resp_data <= {15'h0000, coil_bit(bus_speed_reference_q, req_addr[3:0])};
              end
              else if (req_addr < `DFM_COIL_NVSEL)
              begin
                // status and feedback coils are read-only to the master
                if (req_write)
                  resp_error <= 1'b1;
                else if (req_addr < `DFM_COIL_FBK_BASE)
                  resp_data <= {15'h0000, coil_bit(drive_state_word, req_addr[3:0])};
                else
                  resp_data <= {15'h0000, coil_bit(main_actual_value, req_addr[3:0])};
              end
              else if (req_addr == `DFM_COIL_NVSEL)
              begin
                if (req_write)
                  nv_select_q <= req_wdata[0];
                else
                  resp_data <= {15'h0000, nv_select_q};
              end
              else
                resp_error <= 1'b1;
            end
            else if (in_param_area(hr_num))
            begin
              // parameter p owns registers 10p to 10p+9
              resp_valid <= 1'b0;
              state_q <= ST_WAIT;
              param_req <= 1'b1;
              param_write <= req_write;
              param_number <= param_num_full[12:0];
              param_word <= param_word_full[3:0];
              param_wdata <= req_wdata;
              param_store_nv <= nv_select_q;
              param_array_index <= parameter_array_index_q;
            end
            else
            begin
              case (hr_num)
                `DFM_HR_ERR_NUM:
                  if (req_write) resp_error <= 1'b1;
                  else resp_data <= last_error_code_q;
                `DFM_HR_INDEX_NUM:
                  if (req_write) parameter_array_index_q <= req_wdata;
                  else resp_data <= parameter_array_index_q;
                `DFM_HR_CMD_NUM:
                  if (req_write) drive_command_word_q <= req_wdata;
                  else resp_data <= drive_command_word_q;
                `DFM_HR_REF_NUM:
                  if (req_write) bus_speed_reference_q <= req_wdata;
                  else resp_data <= bus_speed_reference_q;
                `DFM_HR_STATE_NUM:
                  if (req_write) resp_error <= 1'b1;
                  else resp_data <= drive_state_word;
                `DFM_HR_MAV_NUM:
                  if (req_write) resp_error <= 1'b1;
                  else resp_data <= main_actual_value;
                // reserved registers 1-6 and 8 fall here too
                default:
                  resp_error <= 1'b1;
              endcase
            end
          end
        end
        ST_WAIT:
        begin
          // one parameter transfer at a time; new requests wait on req_ready
          if (param_ack)
          begin
            state_q <= ST_IDLE;
            resp_valid <= resp_due_q;
            resp_error <= param_err;
            resp_data <= param_write ? 16'h0000 : param_rdata;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule // dfm_data_map

// ---- testbench/dfm_data_map_asserts.sv ----
`timescale 1ns/10ps
// ----
// request side checks
// ----
module dfm_data_map_chk (
  input logic core_clk, reset, clk_en, req_valid, req_ready, req_is_coil, req_write,
  input logic resp_valid, resp_error, param_req, param_store_nv, store_nonvolatile,
  input logic start_run, reverse,
  input logic [7:0] own_unit_addr, req_unit,
  input logic [12:0] param_number,
  input logic [3:0] param_word,
  input logic [15:0] req_addr, req_wdata, resp_data, main_actual_value, speed_reference
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // a take needs both sides on one edge; broadcast kept apart
  wire own = req_unit == own_unit_addr;
  wire tk = clk_en & req_valid & req_ready;
  wire hr = tk & !req_is_coil & own;
  wire cl = tk & req_is_coil & own;
  start_coil_a: assert property (
    cl && req_write && req_addr == 16'h0006 |=> start_run == $past(req_wdata[0]))
    else $error("start coil not applied");
  reverse_cmd_a: assert property (
    tk && !req_is_coil && req_write && req_addr == 16'hC34F && (own || req_unit == 8'h00)
    |=> reverse == $past(req_wdata[15])) else $error("command word reverse wrong");
  ref_write_a: assert property (
    hr && req_write && req_addr == 16'hC359 |=> speed_reference == $past(req_wdata))
    else $error("speed reference not stored");
  mav_read_a: assert property (
    hr && !req_write && req_addr == 16'hC421
    |=> resp_valid && !resp_error && resp_data == $past(main_actual_value))
    else $error("main value read wrong");
  bcast_quiet_a: assert property (
    tk && !own |=> !resp_valid) else $error("answer to broadcast or other unit");
  ro_write_a: assert property (
    cl && req_write && req_addr[15:5] == 11'h001 |=> resp_valid && resp_error)
    else $error("state or feedback coil written");
  reserved_a: assert property (
    hr && req_addr < 16'h0006 |=> resp_valid && resp_error) else $error("reserved register used");
  param_map_a: assert property (
    hr && req_addr >= 16'd99 && req_addr <= 16'd49998
    |=> param_req && param_number == ({1'b0, $past(req_addr)} + 17'h1) / 17'hA
    && param_word == ({1'b0, $past(req_addr)} + 17'h1) % 17'hA) else $error("parameter map wrong");
  nv_copy_a: assert property (
    param_req |-> param_store_nv == store_nonvolatile) else $error("store select not copied");
  param_block_a: assert property (
    param_req |-> !req_ready ##1 !req_ready) else $error("request taken during parameter access");
  cover property (param_req);
  cover property (tk && req_unit == 8'h00);
  cover property (resp_valid && resp_error);
endmodule // dfm_data_map_chk

bind dfm_data_map dfm_data_map_chk u_dfm_data_map_chk (.*);

// ---- testbench/dfm_param_host.sv ----
`timescale 1ns/10ps
// ----
// parameter store at the far side, acks lag+1 cycles after it samples the request
// ----
module dfm_param_host (
  input logic core_clk, reset, param_req,
  input logic [12:0] param_number,
  input logic [3:0] param_word, lag,
  output logic param_ack, param_err,
  output logic [15:0] param_rdata, param_err_code
);
  logic busy_q;
  logic [3:0] cnt_q;
  logic [15:0] val_q;
  // data not held outside the ack cycle, so a late sample reads garbage
  always @(posedge core_clk)
  begin
    param_ack <= 1'b0;
    param_err <= 1'b0;
    param_rdata <= ~val_q;
    param_err_code <= 16'hFFED;
    if (reset)
      busy_q <= 1'b0;
    else if (param_req)
    begin
      busy_q <= 1'b1;
      cnt_q <= lag;
      val_q <= {param_number[11:0], param_word};
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q <= 1'b0;
      param_ack <= 1'b1;
      param_rdata <= val_q;
      param_err <= val_q[3:0] == 4'h9; // word 9 is refused on purpose
      param_err_code <= 16'h0012;
    end
    else
      cnt_q <= cnt_q - 4'h1;
  end
endmodule // dfm_param_host

// ---- testbench/dfm_data_map_tb_top.sv ----
`timescale 1ns/10ps
module dfm_data_map_tb_top;
  logic core_clk = 0, reset = 1, clk_en = 1, req_valid = 0, req_is_coil = 0, req_write = 0;
  logic [7:0] own_unit_addr = 8'h05, req_unit = 8'h05;
  logic [15:0] req_addr = 0, req_wdata = 0, main_actual_value = 16'h3C5A;
  logic [11:0] stat_v = 12'hFFF;
  logic [3:0] lag = 0, param_word;
  logic req_ready, resp_valid, resp_error, param_req, param_write, param_store_nv, param_ack;
  logic param_err, dc_brake_off, coast_off, quick_stop_off, freeze_off, start_run, fault_reset;
  logic jog, ramp_two, data_valid, relay1_on, relay2_on, reverse, store_nonvolatile, got, gerr;
  logic stat_control_ready, stat_drive_ready, stat_safety_closed, stat_alarm, stat_warning;
  logic stat_at_reference, stat_auto_mode, stat_in_freq_range, stat_running;
  logic stat_voltage_warning, stat_current_limit, stat_thermal_warning;
  logic [15:0] resp_data, param_wdata, param_array_index, param_rdata, param_err_code;
  logic [15:0] speed_reference, gdata;
  logic [12:0] param_number;
  logic [1:0] preset_ref_sel, setup_sel;
  // command outputs in coil order, coil 1 at bit 0
  wire [15:0] cmd_fields = {reverse, setup_sel, relay2_on, relay1_on, data_valid, ramp_two, jog,
    fault_reset, start_run, freeze_off, quick_stop_off, coast_off, dc_brake_off, preset_ref_sel};
  int fail_count = 0, checked = 0;
  typedef struct {logic c, w; logic [15:0] a, d; logic e; logic [15:0] x;} dfm_row_t;
  dfm_row_t rows [14] = '{
    '{1, 1, 16'h0006, 16'h0001, 0, 16'h0000},
    '{0, 0, 16'hC34F, 16'h0000, 0, 16'h0040},
    '{0, 1, 16'hC359, 16'h1234, 0, 16'h0000},
    '{1, 0, 16'h0012, 16'h0000, 0, 16'h0001},
    '{0, 0, 16'hC417, 16'h0000, 0, 16'hEF8F},
    '{0, 0, 16'hC421, 16'h0000, 0, 16'h3C5A},
    '{1, 0, 16'h002C, 16'h0000, 0, 16'h0000},
    '{1, 1, 16'h0020, 16'h0001, 1, 16'h0000},
    '{0, 0, 16'h0000, 16'h0000, 1, 16'h0000},
    '{0, 1, 16'h0008, 16'h0005, 0, 16'h0000},
    '{0, 0, 16'h0008, 16'h0000, 0, 16'h0005},
    '{1, 1, 16'h0040, 16'h0001, 0, 16'h0000},
    '{1, 0, 16'h0040, 16'h0000, 0, 16'h0001},
    '{1, 0, 16'h0041, 16'h0000, 1, 16'h0000}};
  assign {stat_thermal_warning, stat_current_limit, stat_voltage_warning, stat_running,
    stat_in_freq_range, stat_auto_mode, stat_at_reference, stat_warning, stat_alarm,
    stat_safety_closed, stat_drive_ready, stat_control_ready} = stat_v;
  dfm_data_map u_dfm_data_map (.*);
  dfm_param_host u_dfm_param_host (.*);
  // 200 MHz
  always #2.5 core_clk = ~core_clk;
  task chk(input logic [15:0] g, e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one request, then a bounded wait for the answer pulse
  task xfer(input logic [7:0] u, input logic c, w, input logic [15:0] a, d);
    @(negedge core_clk);
    {req_unit, req_is_coil, req_write, req_addr, req_wdata, req_valid} = {u, c, w, a, d, 1'b1};
    @(negedge core_clk);
    req_valid = 0;
    got = 0;
    for (int n = 0; n < 20 && !got; n++)
      if (resp_valid === 1'b1)
        {got, gerr, gdata} = {1'b1, resp_error, resp_data};
      else
        @(negedge core_clk);
  endtask
  task end_sim;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge core_clk);
    reset = 0;
    foreach (rows[i])
    begin
      xfer(8'h05, rows[i].c, rows[i].w, rows[i].a, rows[i].d);
      chk(got, 16'h1);
      chk(gerr, rows[i].e);
      if (!rows[i].e) chk(gdata, rows[i].x);
    end
    $display("table test done");
    // uneven status pattern so that swapped state bits show up
    stat_v = 12'h5A6;
    xfer(8'h05, 0, 0, 16'hC417, 16'h0);
    chk(gdata, 16'h4D06);
    xfer(8'h05, 1, 0, 16'h0022, 16'h0);
    chk(gdata, 16'h0001);
    $display("status test done");
    xfer(8'h00, 0, 1, 16'hC34F, 16'h8041);
    chk(got, 16'h0);
    chk({reverse, start_run, preset_ref_sel}, 16'hD);
    xfer(8'h00, 0, 0, 16'hC417, 16'h0);
    chk(got, 16'h0);
    xfer(8'h09, 1, 1, 16'h000F, 16'h0);
    chk({got, reverse}, 16'h1);
    // frozen clock enable: a request must be neither taken nor answered
    clk_en = 0;
    xfer(8'h05, 1, 1, 16'h000F, 16'h0);
    chk({got, reverse}, 16'h1);
    clk_en = 1;
    $display("broadcast test done");
    lag = 4'h6;
    xfer(8'h05, 0, 0, 16'd999, 16'h0);
    chk(gdata, 16'h0640);
    lag = 4'h0;
    xfer(8'h05, 0, 0, 16'd1008, 16'h0);
    chk(gerr, 16'h1);
    xfer(8'h05, 0, 0, 16'h0006, 16'h0);
    chk(gdata, 16'h0012);
    xfer(8'h05, 0, 1, 16'd2004, 16'hBEEF);
    chk(gdata, 16'h0000);
    chk({param_write, param_store_nv}, 16'h3);
    chk(param_wdata, 16'hBEEF);
    chk(param_array_index, 16'h0005);
    chk({param_number[11:0], param_word}, 16'h0C85);
    $display("parameter test done");
    xfer(8'h05, 0, 1, 16'hC34F, 16'h5A3C);
    chk(cmd_fields, 16'h5A3C);
    // mid-run reset must clear every stored item
    reset = 1;
    repeat (2) @(negedge core_clk);
    chk(cmd_fields, 16'h0000);
    chk(speed_reference, 16'h0000);
    chk(param_array_index, 16'h0000);
    chk({store_nonvolatile, resp_valid, req_ready}, 16'h1);
    reset = 0;
    xfer(8'h05, 0, 0, 16'h0006, 16'h0);
    chk(gdata, 16'h0000);
    $display("reset test done");
    end_sim;
  end
endmodule // dfm_data_map_tb_top
